// File: rtl/cpw_pkg.sv
/*
  Package for the compare PWM channel: register offsets, field positions,
  mode codes and reset values shared by the channel and its helpers.
  Assumes a 32-bit APB master and a single 250 MHz system clock.
*/
package cpw_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] CPW_CTRL_ONE_OFS = 8'h00;
  localparam logic [7:0] CPW_CTRL_TWO_OFS = 8'h04;
  localparam logic [7:0] CPW_PRIMARY_OFS = 8'h08;
  localparam logic [7:0] CPW_SECONDARY_OFS = 8'h0c;
  localparam logic [7:0] CPW_TIMER_OFS = 8'h10;
  localparam logic [7:0] CPW_CLKDIV_OFS = 8'h14;

  // Fields of channel_control_one.
  localparam int CPW_MODE_LSB = 0;
  localparam int CPW_FLT_STAT_LSB = 4;
  localparam int CPW_FLT_EN_LSB = 7;
  localparam int CPW_IFLAG_BIT = 10;

  // Fields of channel_control_two.
  localparam int CPW_SYNC_LSB = 0;
  localparam int CPW_TRIG_STAT_BIT = 6;
  localparam int CPW_TRIG_SEL_BIT = 7;
  localparam int CPW_FLT_TRI_BIT = 13;
  localparam int CPW_FLT_LVL_BIT = 14;
  localparam int CPW_FLT_MODE_BIT = 15;

  // Channel mode codes.
  localparam logic [2:0] CPW_MODE_PULSE = 3'h5;
  localparam logic [2:0] CPW_MODE_EDGE = 3'h6;
  localparam logic [2:0] CPW_MODE_CENTER = 3'h7;

  // Sync source code that selects this channel's own secondary match.
  localparam logic [4:0] CPW_SYNC_SELF = 5'h1f;
  localparam logic [4:0] CPW_SYNC_NONE = 5'h00;

  // Timer constants and reset values.
  localparam logic [15:0] CPW_TMR_MAX = 16'hffff;
  localparam logic [15:0] CPW_ZERO16 = 16'h0000;
  localparam logic [15:0] CPW_CLKDIV_RST = 16'h0000;

endpackage : cpw_pkg

// File: rtl/cpw_clk_div.sv
/*
  Timer clock divider: turns the system clock into a one-cycle tick pulse.
  Assumes a synchronous active-high reset on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cpw_clk_div
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] div_i,
  output logic tick_o
);
  import cpw_pkg::*;

  logic [15:0] cnt_ff; // Cycles since the last tick.
  logic [15:0] nxt_cnt;
  logic hit;           // Count has reached the divide value.

  assign hit = (cnt_ff >= div_i);
  assign nxt_cnt = hit ? CPW_ZERO16 : cnt_ff + 16'h0001;

  // A divide value of zero gives a tick on every cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= CPW_ZERO16;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_o <= hit;
    end
  end

endmodule : cpw_clk_div
`default_nettype wire

// File: rtl/cpw_fault_latch.sv
/*
  One fault input: enable gating, status bit and fault condition hold.
  Assumes the fault input is synchronous to the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cpw_fault_latch
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic active_i,    // PWM mode is selected.
  input wire logic enable_i,    // fault_input_enable for this input.
  input wire logic fault_i,     // Raw fault input, active high.
  input wire logic latched_i,   // fault_recovery_mode.
  input wire logic clr_stat_i,  // Software clears the status bit.
  input wire logic new_cycle_i, // Timer starts a new cycle.
  output logic status_o,        // fault_input_status.
  output logic cond_o           // Fault condition held.
);
  logic hit; // Enabled fault seen in a PWM mode.
  logic release_ok;

  assign hit = active_i & enable_i & fault_i; // [R9]
  // Latched recovery also needs status cleared first.
  assign release_ok = new_cycle_i & ~fault_i & (~latched_i | ~status_o);

  // Status set wins over a software clear in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_o <= 1'b0;
      cond_o <= 1'b0;
    end
    else
    begin
      status_o <= hit | (status_o & ~clr_stat_i); // [R10]
      if (hit)
        cond_o <= 1'b1;
      else if (release_ok | ~active_i)
        cond_o <= 1'b0; // [R12] [R13]
    end
  end

endmodule : cpw_fault_latch
`default_nettype wire

// File: rtl/cpw_channel.sv
/*
  Compare PWM channel: edge and center aligned PWM with buffered compare
  values, three fault inputs, synchronous and triggered timer control,
  and an APB register slave.
  Assumes one 250 MHz system clock, inputs synchronous to it, and an APB
  master that holds each request until pready.
*/
// Local design decisions: the address map and register access over APB.
// Functional notes
// R1: Modes 110/111 double-buffer, reload on boundary.
// R2: Edge mode: primary duty, sync sets period.
// R3: Sync: zero timer, output high, reload, flag.
// R4: Edge mode duty match drives output low.
// R5: Entering edge mode: low if duty zero.
// R6: First duty match clears until next period.
// R7: Duty zero low; duty above period high.
// R8: Center mode: rise primary, fall secondary.
// R9: Three fault inputs each gated by enable.
// R10: Status bit per enabled active fault.
// R11: Fault forces level or tri-states output.
// R12: Latched recovery needs status clear too.
// R13: Cycle recovery: input inactive, new cycle.
// R14: Trigger select zero: synchronous, status ignored.
// R15: Sync returns timer to zero next tick.
// R16: Secondary match emits sync output.
// R17: Software enables sync source channel last.
// R18: Trigger select one: hold until trigger.
// R19: Software setup order for edge PWM.
// R20: Synchronized channels share one clock source.
// R21: Trigger status zero holds timer reset.
// R22: 16-bit timer wraps, wrap is boundary.
`timescale 1ns/1ns
`default_nettype none
module cpw_channel
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [30:0] SYNC_SOURCES_I, // Sibling sync/trigger lines 1..31.
  input wire logic FAULT_INPUT_A_I,
  input wire logic FAULT_INPUT_B_I,
  input wire logic FAULT_INPUT_C_I,
  output logic COMPARE_OUTPUT_PIN_O,
  output logic COMPARE_OUTPUT_PIN_OE_O,
  output logic SYNC_OUT_O,
  output logic CHANNEL_INTERRUPT_FLAG_O
);
  import cpw_pkg::*;

  // Software-visible control fields.
  logic [2:0] mode_ff;        // channel_mode_select.
  logic [2:0] flt_en_ff;      // fault_input_enable C,B,A.
  logic [4:0] sync_sel_ff;    // sync_trigger_source_select.
  logic trig_sel_ff;          // trigger_select.
  logic trig_stat_ff;         // trigger_status.
  logic flt_tri_ff;           // fault_tristate_enable.
  logic flt_lvl_ff;           // fault_output_level.
  logic flt_mode_ff;          // fault_recovery_mode.
  logic [15:0] pri_ff;        // primary_compare_value as written.
  logic [15:0] sec_ff;        // secondary_compare_value as written.
  logic [15:0] pri_buf_ff;    // Buffered duty / rising compare.
  logic [15:0] sec_buf_ff;    // Buffered period / falling compare.
  logic [15:0] tmr_ff;        // channel_timer.
  logic [15:0] clkdiv_ff;     // Timer clock divide value.
  logic iflag_ff;             // channel_interrupt_flag.
  logic out_ff;               // Waveform level before fault override.
  logic sync_pend_ff;         // Sync seen, acts on next timer tick.
  logic [2:0] mode_prev_ff;   // Mode last cycle, for entry detection.

  // Bus decode.
  logic wr_en;
  logic rd_en;
  logic sel_c1;
  logic sel_c2;
  logic sel_pri;
  logic sel_sec;
  logic sel_tmr;
  logic sel_div;
  logic mapped;

  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_en = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign sel_c1 = (PADDR_I == CPW_CTRL_ONE_OFS);
  assign sel_c2 = (PADDR_I == CPW_CTRL_TWO_OFS);
  assign sel_pri = (PADDR_I == CPW_PRIMARY_OFS);
  assign sel_sec = (PADDR_I == CPW_SECONDARY_OFS);
  assign sel_tmr = (PADDR_I == CPW_TIMER_OFS);
  assign sel_div = (PADDR_I == CPW_CLKDIV_OFS);
  assign mapped = sel_c1 | sel_c2 | sel_pri | sel_sec | sel_tmr | sel_div;

  // Mode and timing decode.
  logic pwm_on;
  logic edge_on;
  logic center_on;
  logic tick;
  logic sel_line;
  logic self_sync;
  logic sec_match;
  logic pri_match;
  logic wrap;
  logic boundary;
  logic run;
  logic edge_enter;
  logic [2:0] flt_stat;
  logic [2:0] flt_cond;
  logic any_fault;
  logic clr_stat_a;
  logic clr_stat_b;
  logic clr_stat_c;

  assign pwm_on = (mode_ff == CPW_MODE_EDGE) | (mode_ff == CPW_MODE_CENTER);
  assign edge_on = (mode_ff == CPW_MODE_EDGE);
  assign center_on = (mode_ff == CPW_MODE_CENTER);
  assign edge_enter = edge_on & (mode_prev_ff != CPW_MODE_EDGE);
  assign self_sync = (sync_sel_ff == CPW_SYNC_SELF);
  assign sec_match = pwm_on & (tmr_ff == sec_buf_ff); // [R16]
  assign pri_match = (tmr_ff == pri_buf_ff);
  // Select line: 0x1f is our own secondary match; 0 is no source.
  assign sel_line = self_sync ? SYNC_OUT_O :
                    (sync_sel_ff == CPW_SYNC_NONE) ? 1'b0 :
                    SYNC_SOURCES_I[sync_sel_ff - 5'h01];
  assign wrap = tick & (tmr_ff == CPW_TMR_MAX); // [R22]
  // A synchronous sync, applied on the tick, starts a new period.
  assign boundary = tick & ((sync_pend_ff & ~trig_sel_ff) | wrap); // [R1]
  // Trigger mode runs only while trigger status is set.
  assign run = ~trig_sel_ff | trig_stat_ff; // [R14] [R18] [R21]
  assign clr_stat_a = wr_en & sel_c1 & ~PWDATA_I[CPW_FLT_STAT_LSB];
  assign clr_stat_b = wr_en & sel_c1 & ~PWDATA_I[CPW_FLT_STAT_LSB + 1];
  assign clr_stat_c = wr_en & sel_c1 & ~PWDATA_I[CPW_FLT_STAT_LSB + 2];
  assign any_fault = |flt_cond;

  // Timer tick divider: the selected timer clock as an enable.
  cpw_clk_div u_div
  (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .div_i(clkdiv_ff),
    .tick_o(tick)
  );

  // Three fault blocks, one per fault input.
  cpw_fault_latch u_flt_a
  (
    .clk_i(CLK_SYS_I), .rst_i(RESET_I), .active_i(pwm_on),
    .enable_i(flt_en_ff[0]), .fault_i(FAULT_INPUT_A_I),
    .latched_i(flt_mode_ff), .clr_stat_i(clr_stat_a),
    .new_cycle_i(boundary), .status_o(flt_stat[0]), .cond_o(flt_cond[0])
  );
  cpw_fault_latch u_flt_b
  (
    .clk_i(CLK_SYS_I), .rst_i(RESET_I), .active_i(pwm_on),
    .enable_i(flt_en_ff[1]), .fault_i(FAULT_INPUT_B_I),
    .latched_i(flt_mode_ff), .clr_stat_i(clr_stat_b),
    .new_cycle_i(boundary), .status_o(flt_stat[1]), .cond_o(flt_cond[1])
  );
  cpw_fault_latch u_flt_c
  (
    .clk_i(CLK_SYS_I), .rst_i(RESET_I), .active_i(pwm_on),
    .enable_i(flt_en_ff[2]), .fault_i(FAULT_INPUT_C_I),
    .latched_i(flt_mode_ff), .clr_stat_i(clr_stat_c),
    .new_cycle_i(boundary), .status_o(flt_stat[2]), .cond_o(flt_cond[2])
  );

  // Next values of timer and waveform.
  logic [15:0] nxt_tmr;
  logic nxt_out;
  logic nxt_trig_stat;

  // Timer: held at zero while stopped, zeroed by sync on the tick.
  always_comb
  begin
    nxt_tmr = tmr_ff;
    if (!run || !pwm_on)
      nxt_tmr = CPW_ZERO16; // [R21] [R18]
    else if (tick && sync_pend_ff && !trig_sel_ff)
      nxt_tmr = CPW_ZERO16; // [R15] [R3]
    else if (tick)
      nxt_tmr = tmr_ff + 16'h0001; // [R22]
  end

  // Waveform level; faults are applied later at the pin.
  always_comb
  begin
    nxt_out = out_ff;
    if (!pwm_on)
      nxt_out = 1'b0;
    else if (edge_enter)
      nxt_out = (pri_ff != CPW_ZERO16); // [R5]
    else if (edge_on && boundary)
      // New period: high unless duty or period zero; a coincident
      // duty match loses to the period start.
      nxt_out = (pri_ff != CPW_ZERO16) & (sec_ff != CPW_ZERO16); // [R3] [R7]
    else if (edge_on && tick && pri_match && !(pri_buf_ff > sec_buf_ff))
      nxt_out = 1'b0; // [R4] [R6] [R7]
    else if (center_on && tick && pri_match && pri_buf_ff != sec_buf_ff)
      nxt_out = 1'b1; // [R8]
    else if (center_on && tick && sec_match)
      nxt_out = 1'b0; // [R8]
  end

  // Trigger status: set by the selected trigger, software write either way.
  always_comb
  begin
    nxt_trig_stat = trig_stat_ff;
    if (wr_en && sel_c2)
      nxt_trig_stat = PWDATA_I[CPW_TRIG_STAT_BIT];
    // A trigger in the same cycle as a software clear wins, so no event
    // is lost to the clear.
    if (trig_sel_ff && sel_line && !self_sync)
      nxt_trig_stat = 1'b1; // [R18]
  end

  // Control registers written by software.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      mode_ff <= 3'h0;
      flt_en_ff <= 3'h0;
      sync_sel_ff <= 5'h00;
      trig_sel_ff <= 1'b0;
      flt_tri_ff <= 1'b0;
      flt_lvl_ff <= 1'b0;
      flt_mode_ff <= 1'b0;
      pri_ff <= CPW_ZERO16;
      sec_ff <= CPW_ZERO16;
      clkdiv_ff <= CPW_CLKDIV_RST;
    end
    else if (wr_en)
    begin
      if (sel_c1)
      begin
        mode_ff <= PWDATA_I[CPW_MODE_LSB +: 3];
        flt_en_ff <= PWDATA_I[CPW_FLT_EN_LSB +: 3]; // [R9]
      end
      if (sel_c2)
      begin
        sync_sel_ff <= PWDATA_I[CPW_SYNC_LSB +: 5]; // [R2]
        trig_sel_ff <= PWDATA_I[CPW_TRIG_SEL_BIT];
        flt_tri_ff <= PWDATA_I[CPW_FLT_TRI_BIT];
        flt_lvl_ff <= PWDATA_I[CPW_FLT_LVL_BIT];
        flt_mode_ff <= PWDATA_I[CPW_FLT_MODE_BIT];
      end
      if (sel_pri)
        pri_ff <= PWDATA_I[15:0];
      if (sel_sec)
        sec_ff <= PWDATA_I[15:0];
      if (sel_div)
        clkdiv_ff <= PWDATA_I[15:0];
    end
  end

  // Buffered compares load on entry and at each period boundary.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      pri_buf_ff <= CPW_ZERO16;
      sec_buf_ff <= CPW_ZERO16;
    end
    else if (!pwm_on || edge_enter || boundary)
    begin
      pri_buf_ff <= pri_ff; // [R1] [R3]
      sec_buf_ff <= sec_ff;
    end
  end

  // Timer, waveform, sync and flags.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      tmr_ff <= CPW_ZERO16;
      out_ff <= 1'b0;
      trig_stat_ff <= 1'b0;
      sync_pend_ff <= 1'b0;
      mode_prev_ff <= 3'h0;
      iflag_ff <= 1'b0;
    end
    else
    begin
      tmr_ff <= nxt_tmr;
      out_ff <= nxt_out;
      trig_stat_ff <= nxt_trig_stat;
      mode_prev_ff <= mode_ff;
      // A sync waits for the next tick; it is cleared when used.
      sync_pend_ff <= (sync_pend_ff & ~tick) | (sel_line & ~trig_sel_ff);
      // Flag set wins over software clear in the same cycle.
      iflag_ff <= (edge_on & boundary & (sync_pend_ff | wrap)) |
                  (iflag_ff & ~(wr_en & sel_c1 &
                   ~PWDATA_I[CPW_IFLAG_BIT])); // [R3]
    end
  end

  // Pin and sync outputs, all registered.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      COMPARE_OUTPUT_PIN_O <= 1'b0;
      COMPARE_OUTPUT_PIN_OE_O <= 1'b0;
      SYNC_OUT_O <= 1'b0;
      CHANNEL_INTERRUPT_FLAG_O <= 1'b0;
    end
    else
    begin
      COMPARE_OUTPUT_PIN_O <= any_fault ? flt_lvl_ff : nxt_out; // [R11]
      COMPARE_OUTPUT_PIN_OE_O <= ~(any_fault & flt_tri_ff); // [R11]
      SYNC_OUT_O <= tick & sec_match; // [R16]
      CHANNEL_INTERRUPT_FLAG_O <= iflag_ff;
    end
  end

  // APB slave: zero wait, read data captured in the setup phase.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      PRDATA_O <= 32'h0000_0000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~mapped;
      if (rd_en)
      begin
        PRDATA_O <= 32'h0000_0000;
        if (sel_c1)
        begin
          PRDATA_O[CPW_MODE_LSB +: 3] <= mode_ff;
          PRDATA_O[CPW_FLT_STAT_LSB +: 3] <= flt_stat; // [R10]
          PRDATA_O[CPW_FLT_EN_LSB +: 3] <= flt_en_ff;
          PRDATA_O[CPW_IFLAG_BIT] <= iflag_ff;
        end
        if (sel_c2)
        begin
          PRDATA_O[CPW_SYNC_LSB +: 5] <= sync_sel_ff;
          PRDATA_O[CPW_TRIG_STAT_BIT] <= trig_stat_ff;
          PRDATA_O[CPW_TRIG_SEL_BIT] <= trig_sel_ff;
          PRDATA_O[CPW_FLT_TRI_BIT] <= flt_tri_ff;
          PRDATA_O[CPW_FLT_LVL_BIT] <= flt_lvl_ff;
          PRDATA_O[CPW_FLT_MODE_BIT] <= flt_mode_ff;
        end
        if (sel_pri)
          PRDATA_O[15:0] <= pri_ff;
        if (sel_sec)
          PRDATA_O[15:0] <= sec_ff;
        if (sel_tmr)
          PRDATA_O[15:0] <= tmr_ff;
        if (sel_div)
          PRDATA_O[15:0] <= clkdiv_ff;
      end
    end
  end

  // Checks on the behaviour above.
  hold_stop_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (trig_sel_ff && !trig_stat_ff) |=> tmr_ff == CPW_ZERO16) // [R21]
    else $error("timer moved while trigger status was clear");
  duty_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (edge_on && $stable(mode_ff) && pri_ff == CPW_ZERO16 &&
     pri_buf_ff == CPW_ZERO16 && !any_fault) |=> !out_ff) // [R7]
    else $error("output high with zero duty");
  flt_force_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    any_fault |=> COMPARE_OUTPUT_PIN_O == $past(flt_lvl_ff)) // [R11]
    else $error("fault level not driven");
  flt_tri_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (any_fault && flt_tri_ff) |=> !COMPARE_OUTPUT_PIN_OE_O) // [R11]
    else $error("pin driven during tri-state fault");
  ignore_flt_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (!flt_en_ff[0] && !flt_stat[0]) |=> !flt_stat[0] || $past(wr_en)) // [R9]
    else $error("disabled fault set its status");
  sync_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (run && pwm_on && tick && sync_pend_ff && !trig_sel_ff &&
     !(wr_en && (sel_c1 || sel_c2))) |=> tmr_ff == CPW_ZERO16) // [R15]
    else $error("sync did not zero the timer");
  wrap_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (run && pwm_on && wrap && !(wr_en && (sel_c1 || sel_c2)))
    |=> tmr_ff == CPW_ZERO16) // [R22]
    else $error("timer did not wrap to zero");
  sync_out_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (tick && sec_match) |=> SYNC_OUT_O) // [R16]
    else $error("secondary match gave no sync out");
  reload_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (pwm_on && !edge_enter && !boundary) |=> $stable(pri_buf_ff)) // [R1]
    else $error("buffered duty changed mid period");
  flag_set_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (edge_on && boundary) |=> iflag_ff ##1 CHANNEL_INTERRUPT_FLAG_O) // [R3]
    else $error("period start did not raise the flag");

endmodule : cpw_channel
`default_nettype wire

// File: test/cpw_sync_partner.sv
/*
  Sibling channel model: raises one sync or trigger line for one cycle.
  Assumes the same system clock as the channel under test.
*/
`timescale 1ns/1ns
`default_nettype none
module cpw_sync_partner
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fire_i,
  input wire logic [4:0] line_i,
  output logic [30:0] lines_o
);
  // A sibling shares the channel clock, so its pulse lands on a tick.
  // Codes 0 and 0x1f name no sibling line, so nothing is raised for them.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !fire_i || line_i == 5'h00 || line_i == 5'h1f)
      lines_o <= 31'h00000000;
    else
      lines_o <= 31'h00000001 << (line_i - 5'h01);
  end
endmodule : cpw_sync_partner
`default_nettype wire

// File: test/testbench.sv
/*
  Self-checking bench for the compare PWM channel.
  Assumes an APB slave with no wait states and the sibling sync model.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import cpw_pkg::*;
  logic clk = 1'b0; // System clock, 4 ns period.
  logic rst = 1'b1; // Synchronous reset, held for 8 cycles.
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [30:0] lines;
  logic fa = 1'b0; // Fault inputs, active high.
  logic fb = 1'b0;
  logic fc = 1'b0;
  logic pin;
  logic oe;
  logic sout;
  logic flag;
  logic fire = 1'b0;
  logic [4:0] fline = 5'h00;
  logic [31:0] seed = 32'he5a0; // Fixed seed keeps runs repeatable.
  logic [31:0] rv;
  logic [31:0] d;
  logic err;
  int n_mismatch = 0;
  int cmp_count = 0;
  int hi;
  int so;

  // Free-running clock.
  always #2 clk = ~clk;

  cpw_channel u_dut
  (
    .CLK_SYS_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SYNC_SOURCES_I(lines), .FAULT_INPUT_A_I(fa), .FAULT_INPUT_B_I(fb),
    .FAULT_INPUT_C_I(fc), .COMPARE_OUTPUT_PIN_O(pin),
    .COMPARE_OUTPUT_PIN_OE_O(oe), .SYNC_OUT_O(sout),
    .CHANNEL_INTERRUPT_FLAG_O(flag)
  );

  cpw_sync_partner u_sib
  (
    .clk_i(clk), .rst_i(rst), .fire_i(fire), .line_i(fline), .lines_o(lines)
  );

  // Xorshift generator for the random register traffic.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Control word one: mode, enables, status written 0 (clears them).
  function automatic logic [31:0] ctl1(input logic [2:0] m,
                                       input logic [2:0] en);
    return {22'h000000, en, 4'h0, m};
  endfunction : ctl1

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [31:0] v, input int lo, input int up);
    cmp_count++;
    if ($isunknown(v) || v < lo || v > up)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %h outside %0d..%0d", $time, v, lo, up);
    end
  endtask : chk_rng

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    // No timeout here; the wait ends on ready, or when the watchdog ends the run.
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Counts high pin cycles and sync pulses over a window.
  task automatic watch(input int n);
    hi = 0;
    so = 0;
    repeat (n)
    begin
      @(posedge clk);
      hi += (pin === 1'b1);
      so += (sout === 1'b1);
    end
  endtask : watch

  task automatic pulse(input logic [4:0] l);
    @(posedge clk);
    fire <= 1'b1;
    fline <= l;
    @(posedge clk);
    fire <= 1'b0;
  endtask : pulse

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // Watchdog: far beyond the several hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, CPW_TIMER_OFS, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({rv[30:0], err}, 32'h1);
    // Random compare values read back as their low half only.
    repeat (4)
    begin
      d = xs();
      apb(1'b1, CPW_PRIMARY_OFS, d);
      apb(1'b0, CPW_PRIMARY_OFS, 32'h0);
      chk(rv, {16'h0000, d[15:0]});
    end
    // Setup order: on-time, period, self sync, clock, then mode.
    apb(1'b1, CPW_PRIMARY_OFS, 32'h0);
    apb(1'b1, CPW_SECONDARY_OFS, 32'h4);
    apb(1'b1, CPW_CTRL_TWO_OFS, {27'h0, CPW_SYNC_SELF});
    apb(1'b1, CPW_CLKDIV_OFS, 32'h0);
    apb(1'b1, CPW_CTRL_ONE_OFS, ctl1(CPW_MODE_EDGE, 3'h0));
    @(posedge clk);
    #1;
    chk({31'h0, pin}, 32'h0);
    watch(30);
    chk_rng(hi, 0, 0);
    apb(1'b1, CPW_CTRL_ONE_OFS, 32'h0);
    apb(1'b1, CPW_PRIMARY_OFS, 32'h2);
    apb(1'b1, CPW_CTRL_ONE_OFS, ctl1(CPW_MODE_EDGE, 3'h0));
    @(posedge clk);
    #1;
    chk({31'h0, pin}, 32'h1);
    watch(60);
    chk_rng(hi, 1, 59);
    chk_rng(so, 1, 30);
    chk({31'h0, flag}, 32'h1);
    // Duty above the period takes effect at a reload and holds high.
    apb(1'b1, CPW_PRIMARY_OFS, 32'h9);
    watch(20);
    watch(30);
    chk_rng(hi, 30, 30);
    apb(1'b1, CPW_PRIMARY_OFS, 32'h2);
    apb(1'b1, CPW_CTRL_ONE_OFS, ctl1(CPW_MODE_CENTER, 3'h0));
    watch(20);
    watch(60);
    chk_rng(hi, 1, 59);
    // Fault A enabled, level high, cycle-by-cycle; B stays disabled.
    apb(1'b1, CPW_CTRL_ONE_OFS, ctl1(CPW_MODE_EDGE, 3'h1));
    apb(1'b1, CPW_CTRL_TWO_OFS, 32'h401f);
    @(posedge clk);
    fa <= 1'b1;
    fb <= 1'b1;
    fc <= 1'b1;
    watch(5);
    watch(30);
    chk_rng(hi, 30, 30);
    apb(1'b0, CPW_CTRL_ONE_OFS, 32'h0);
    chk({29'h0, rv[6:4]}, 32'h1);
    fa <= 1'b0;
    watch(20);
    watch(60);
    chk_rng(hi, 1, 59);
    // Latched recovery waits for software to clear the status.
    apb(1'b1, CPW_CTRL_TWO_OFS, 32'hc01f);
    rv = xs();
    @(posedge clk);
    fa <= 1'b1;
    repeat (int'(rv[2:0]) + 2) @(posedge clk);
    fa <= 1'b0;
    watch(30);
    chk_rng(hi, 30, 30);
    apb(1'b1, CPW_CTRL_ONE_OFS, ctl1(CPW_MODE_EDGE, 3'h1));
    watch(20);
    watch(60);
    chk_rng(hi, 1, 59);
    apb(1'b1, CPW_CTRL_TWO_OFS, 32'h201f);
    @(posedge clk);
    fa <= 1'b1;
    watch(5);
    chk({31'h0, oe}, 32'h0);
    fa <= 1'b0;
    fb <= 1'b0;
    fc <= 1'b0;
    watch(20);
    chk({31'h0, oe}, 32'h1);
    // Triggered timer: held at zero until the chosen line fires.
    apb(1'b1, CPW_CTRL_ONE_OFS, ctl1(CPW_MODE_EDGE, 3'h0));
    apb(1'b1, CPW_CTRL_TWO_OFS, 32'h81);
    pulse(5'h03);
    repeat (6) @(posedge clk);
    apb(1'b0, CPW_TIMER_OFS, 32'h0);
    chk(rv, 32'h0);
    pulse(5'h01);
    repeat (10) @(posedge clk);
    apb(1'b0, CPW_TIMER_OFS, 32'h0);
    chk_rng(rv, 1, 40);
    apb(1'b1, CPW_CTRL_TWO_OFS, 32'h81);
    apb(1'b0, CPW_TIMER_OFS, 32'h0);
    chk(rv, 32'h0);
    // Synchronous timer on sibling line 2; status bit has no effect.
    apb(1'b1, CPW_PRIMARY_OFS, 32'h80);
    apb(1'b1, CPW_SECONDARY_OFS, 32'h100);
    watch(20);
    apb(1'b1, CPW_CTRL_TWO_OFS, 32'h42);
    watch(40);
    apb(1'b0, CPW_TIMER_OFS, 32'h0);
    chk_rng(rv, 20, 255);
    pulse(5'h02);
    repeat (4) @(posedge clk);
    apb(1'b0, CPW_TIMER_OFS, 32'h0);
    chk_rng(rv, 0, 12);
    final_report();
  end
endmodule : testbench
`default_nettype wire
